// File: design/tps_supervisor.sv
// Thermal protection supervisor: block shutdowns, prewarning and chip shutdown.
// Assumes comparator inputs are asynchronous; control strobes come from SYS_CLK logic.
`timescale 1ns/1ps
`default_nettype none
`include "tps_defines.svh"

module tps_supervisor
    import tps_pkg::*;
#(
    parameter int N_HS             = 4,
    parameter int COOLDOWN_CYCLES  = `TPS_COOLDOWN_CYCLES,
    parameter int RESTART_CYCLES   = `TPS_RESTART_CYCLES
) (
    input  wire logic            SYS_CLK,
    input  wire logic            RSTN,
    input  wire logic            AUX_OT_RAW,
    input  wire logic            CAN_OT_RAW,
    input  wire logic [N_HS-1:0] HS_OT_RAW,
    input  wire logic            MAIN_PW_RAW,
    input  wire logic            MAIN_SD_RAW,
    input  wire logic            MAIN_SUPPLY_ON,
    input  wire logic            CAN_ON,
    input  wire logic            AUX_CTRL_WR,
    input  wire logic [1:0]      AUX_CTRL_WDATA,
    input  wire logic            HS_CTRL_WR,
    input  wire logic [N_HS-1:0] HS_CTRL_WDATA,
    input  wire logic            CLR_BLOCK_OT,
    input  wire logic            CLR_AUX_OT,
    input  wire logic            CLR_CAN_FAIL,
    input  wire logic [N_HS-1:0] CLR_HS_FAULT,
    input  wire logic            CLR_PREWARN,
    input  wire logic            CLR_CHIP_OT,
    output logic [1:0]           AUX_SUPPLY_ON_CTRL,
    output logic [N_HS-1:0]      HIGH_SIDE_CONTROL,
    output logic                 CAN_TX_EN,
    output logic                 BLOCK_OVERTEMP_FLAG,
    output logic                 AUX_SUPPLY_OVERTEMP_FLAG,
    output logic [1:0]           CAN_FAIL,
    output logic [N_HS-1:0]      HIGH_SIDE_FAULT_FLAG,
    output logic                 THERMAL_PREWARN_FLAG,
    output logic                 CHIP_OVERTEMP_FLAG,
    output logic                 MODE_NORMAL,
    output logic                 MODE_FAILSAFE,
    output logic                 MODE_RESTART
);

    localparam int NRAW = N_HS + 4;

    ////////////////////////////////////////////////////////////////////////////
    // Comparator synchronisers, one pair of flops per raw input.

    logic [NRAW-1:0] raw_in;
    logic [NRAW-1:0] sync_a;
    logic [NRAW-1:0] sync_b;

    assign raw_in = {HS_OT_RAW, MAIN_SD_RAW, MAIN_PW_RAW, CAN_OT_RAW, AUX_OT_RAW};

    genvar gi;
    generate
        for (gi = 0; gi < NRAW; gi++) begin : g_sync
            always_ff @(posedge SYS_CLK or negedge RSTN) begin
                if (!RSTN) begin
                    sync_a[gi] <= 1'h0;
                    sync_b[gi] <= 1'h0;
                end else begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    logic            aux_hot;
    logic            can_hot;
    logic            pw_hot;
    logic            sd_hot;
    logic [N_HS-1:0] hs_hot;

    assign aux_hot = sync_b[0];
    assign can_hot = sync_b[1];
    assign pw_hot  = sync_b[2];
    assign sd_hot  = sync_b[3];
    assign hs_hot  = sync_b[NRAW-1:4];

    ////////////////////////////////////////////////////////////////////////////
    // Block shutdowns and diagnosis flags.

    logic [1:0]      aux_ctrl;
    logic [N_HS-1:0] hs_ctrl;
    logic            can_tx;
    logic            blk_flag;
    logic            aux_flag;
    logic [1:0]      can_fail;
    logic [N_HS-1:0] hs_flag;
    logic            pw_flag;
    logic            chip_flag;
    logic [1:0]      next_aux_ctrl;
    logic [N_HS-1:0] next_hs_ctrl;
    logic            next_can_tx;
    logic            next_blk_flag;
    logic            next_aux_flag;
    logic [1:0]      next_can_fail;
    logic [N_HS-1:0] next_hs_flag;
    logic            next_pw_flag;
    logic            next_chip_flag;

    logic            aux_ev;
    logic            can_ev;
    logic            hs_ev;
    logic            pw_ev;
    logic            sd_ev;
    tps_mode_t       mode;

    // Detection counts only while the block is switched on; clearing looks at the synchronised level, not the on state (the chip flag also needs normal mode),
    // so that a block that has already been turned off can still be acknowledged once cool.
    assign aux_ev = aux_hot && (aux_ctrl != `TPS_AUX_CTRL_RST);
    assign can_ev = can_hot && CAN_ON;
    assign hs_ev  = |(hs_hot & hs_ctrl);
    assign pw_ev  = pw_hot && MAIN_SUPPLY_ON;
    assign sd_ev  = sd_hot && MAIN_SUPPLY_ON;

    always_comb begin
        next_aux_ctrl  = AUX_CTRL_WR ? AUX_CTRL_WDATA : aux_ctrl;
        next_hs_ctrl   = HS_CTRL_WR ? HS_CTRL_WDATA : hs_ctrl;
        next_blk_flag  = blk_flag;
        next_aux_flag  = aux_flag;
        next_can_fail  = can_fail;
        next_hs_flag   = hs_flag;
        next_pw_flag   = pw_flag;
        next_chip_flag = chip_flag;
        // Clears are honoured only once the level has gone, so a set always wins.
        if (CLR_BLOCK_OT && !aux_hot && !can_hot && !(|hs_hot)) begin
            next_blk_flag = 1'h0;
        end
        if (CLR_AUX_OT && !aux_hot) begin
            next_aux_flag = 1'h0;
        end
        if (CLR_CAN_FAIL && !can_hot) begin
            next_can_fail = `TPS_CAN_FAIL_NONE;
        end
        next_hs_flag = hs_flag & ~(CLR_HS_FAULT & ~hs_hot);
        if (CLR_PREWARN && !pw_hot) begin
            next_pw_flag = 1'h0;
        end
        if (CLR_CHIP_OT && !sd_hot && mode == TPS_NORMAL) begin
            next_chip_flag = 1'h0;
        end
        // A shutdown overrides a software write in the same cycle.
        if (aux_ev) begin
            next_aux_ctrl = `TPS_AUX_CTRL_RST;
            next_aux_flag = 1'h1;
        end
        if (can_ev) begin
            next_can_fail = `TPS_CAN_FAIL_OT;
        end
        if (hs_ev) begin
            next_hs_ctrl = '0;
            next_hs_flag = next_hs_flag | hs_ctrl;
        end
        if (aux_ev || can_ev || hs_ev) begin
            next_blk_flag = 1'h1;
        end
        if (pw_ev) begin
            next_pw_flag = 1'h1;
        end
        if (sd_ev) begin
            next_chip_flag = 1'h1;
        end
        // The transceiver stays in its mode; only the transmitter follows the heat.
        next_can_tx = CAN_ON && !can_ev;
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            aux_ctrl  <= `TPS_AUX_CTRL_RST;
            hs_ctrl   <= '0;
            can_tx    <= 1'h0;
            blk_flag  <= `TPS_FLAG_RST;
            aux_flag  <= `TPS_FLAG_RST;
            can_fail  <= `TPS_CAN_FAIL_NONE;
            hs_flag   <= '0;
            pw_flag   <= `TPS_FLAG_RST;
            chip_flag <= `TPS_FLAG_RST;
        end else begin
            aux_ctrl  <= next_aux_ctrl;
            hs_ctrl   <= next_hs_ctrl;
            can_tx    <= next_can_tx;
            blk_flag  <= next_blk_flag;
            aux_flag  <= next_aux_flag;
            can_fail  <= next_can_fail;
            hs_flag   <= next_hs_flag;
            pw_flag   <= next_pw_flag;
            chip_flag <= next_chip_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Chip shutdown: fail-safe for the cool-down, then restart, then normal.

    tps_mode_t   next_mode;
    logic [31:0] count;
    logic [31:0] next_count;

    always_comb begin
        next_mode  = mode;
        next_count = count + 32'h1;
        unique case (mode)
            TPS_NORMAL: begin
                next_count = '0;
            end
            TPS_FAILSAFE: begin
                // A fresh event during cool-down is ignored; the timer is not restarted.
                if (count >= 32'(COOLDOWN_CYCLES - 1)) begin
                    next_mode  = TPS_RESTART;
                    next_count = '0;
                end
            end
            TPS_RESTART: begin
                if (count >= 32'(RESTART_CYCLES - 1)) begin
                    next_mode  = TPS_NORMAL;
                    next_count = '0;
                end
            end
        endcase
        if (sd_ev && mode != TPS_FAILSAFE) begin
            next_mode  = TPS_FAILSAFE;
            next_count = '0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            mode  <= TPS_NORMAL;
            count <= '0;
        end else begin
            mode  <= next_mode;
            count <= next_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all taken from flops.

    assign AUX_SUPPLY_ON_CTRL       = aux_ctrl;
    assign HIGH_SIDE_CONTROL        = hs_ctrl;
    assign CAN_TX_EN                = can_tx;
    assign BLOCK_OVERTEMP_FLAG      = blk_flag;
    assign AUX_SUPPLY_OVERTEMP_FLAG = aux_flag;
    assign CAN_FAIL                 = can_fail;
    assign HIGH_SIDE_FAULT_FLAG     = hs_flag;
    assign THERMAL_PREWARN_FLAG     = pw_flag;
    assign CHIP_OVERTEMP_FLAG       = chip_flag;
    assign MODE_NORMAL              = mode[0];
    assign MODE_FAILSAFE            = mode[1];
    assign MODE_RESTART             = mode[2];

endmodule // tps_supervisor

`default_nettype wire

// File: design/tps_defines.svh
// Constants of the thermal protection supervisor: reset values, codes and times.
// Assumes inclusion by bare name from the supervisor package and module.
`ifndef TPS_DEFINES_SVH
`define TPS_DEFINES_SVH

`define TPS_CLK_MHZ          40
`define TPS_COOLDOWN_MS      100
`define TPS_RESTART_US       1500
`define TPS_COOLDOWN_CYCLES  (`TPS_COOLDOWN_MS * 1000 * `TPS_CLK_MHZ)
`define TPS_RESTART_CYCLES   (`TPS_RESTART_US * `TPS_CLK_MHZ)
`define TPS_CAN_FAIL_NONE    2'h0
`define TPS_CAN_FAIL_OT      2'h1
`define TPS_AUX_CTRL_RST     2'h0
`define TPS_FLAG_RST         1'h0
`define TPS_SYNC_STAGES      2

`endif

// File: design/tps_pkg.sv
// Types shared by the thermal protection supervisor.
// Assumes tps_defines.svh on the include path.
`default_nettype none
`include "tps_defines.svh"

package tps_pkg;
    typedef enum logic [2:0] {
        TPS_NORMAL   = 3'h1,
        TPS_FAILSAFE = 3'h2,
        TPS_RESTART  = 3'h4
    } tps_mode_t;
endpackage

`default_nettype wire

// File: tb/tps_supervisor_asserts.sv
// Checker for the thermal protection supervisor ports.
// Assumes it is bound into tps_supervisor and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tps_supervisor_asserts #(
    parameter int N_HS            = 4,
    parameter int COOLDOWN_CYCLES = 20
) (
    input wire logic            SYS_CLK,
    input wire logic            RSTN,
    input wire logic            CAN_OT_RAW,
    input wire logic            MAIN_SUPPLY_ON,
    input wire logic            CAN_ON,
    input wire logic            CLR_CHIP_OT,
    input wire logic [1:0]      AUX_SUPPLY_ON_CTRL,
    input wire logic [N_HS-1:0] HIGH_SIDE_CONTROL,
    input wire logic            CAN_TX_EN,
    input wire logic            BLOCK_OVERTEMP_FLAG,
    input wire logic            AUX_SUPPLY_OVERTEMP_FLAG,
    input wire logic [1:0]      CAN_FAIL,
    input wire logic [N_HS-1:0] HIGH_SIDE_FAULT_FLAG,
    input wire logic            THERMAL_PREWARN_FLAG,
    input wire logic            CHIP_OVERTEMP_FLAG,
    input wire logic            MODE_NORMAL,
    input wire logic            MODE_FAILSAFE,
    input wire logic            MODE_RESTART
);
////////////////////////////////////////
    int fs_cnt;
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fs_cnt <= 0;
        end else begin
            fs_cnt <= MODE_FAILSAFE ? fs_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    sequence s_restart_run;
        MODE_RESTART [*8];
    endsequence
    a_aux_shut: assert property ($rose(AUX_SUPPLY_OVERTEMP_FLAG) |->
        AUX_SUPPLY_ON_CTRL == 2'h0 && BLOCK_OVERTEMP_FLAG && $past(AUX_SUPPLY_ON_CTRL) != 2'h0) else $error("aux");
    a_can_hot: assert property ((CAN_ON && CAN_OT_RAW) [*4] |->
        !CAN_TX_EN && CAN_FAIL == 2'h1) else $error("can hot");
    a_can_back: assert property ((CAN_ON && !CAN_OT_RAW) [*5] |-> CAN_TX_EN)
        else $error("can back");
    a_hs_all_off: assert property ((HIGH_SIDE_FAULT_FLAG & ~$past(HIGH_SIDE_FAULT_FLAG)) != '0 |->
        HIGH_SIDE_CONTROL == '0) else $error("hs");
    a_pw_gate: assert property ($rose(THERMAL_PREWARN_FLAG) |-> $past(MAIN_SUPPLY_ON))
        else $error("prewarn");
    a_chip_enter: assert property ($rose(MODE_FAILSAFE) |->
        CHIP_OVERTEMP_FLAG && $past(MAIN_SUPPLY_ON)) else $error("chip");
    a_cool_len: assert property ($fell(MODE_FAILSAFE) |->
        fs_cnt == COOLDOWN_CYCLES ##0 s_restart_run) else $error("cooldown");
    a_chip_clr: assert property ($fell(CHIP_OVERTEMP_FLAG) |->
        $past(CLR_CHIP_OT) && $past(MODE_NORMAL)) else $error("chip clear");
endmodule // tps_supervisor_asserts
`default_nettype wire

// File: tb/tps_mcu_model.sv
// Microcontroller side: one-cycle flag clear strobes on request.
// Assumes the bench raises go for one cycle with the wanted mask.
`timescale 1ns/1ps
`default_nettype none
module tps_mcu_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       go,
    input  wire logic [8:0] mask,
    output logic      [8:0] clr
);
////////////////////////////////////////
    // Nothing is cleared unasked, so stuck flags stay visible.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clr <= 9'h000;
        end else begin
            clr <= go ? mask : 9'h000;
        end
    end
endmodule // tps_mcu_model
`default_nettype wire

// File: tb/tb.sv
// Top bench of the thermal protection supervisor.
// Assumes short cool-down and restart counts for a quick run.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       SYS_CLK = 1'h0;
    logic       RSTN = 1'h0;
    logic       aux_ot, can_ot, pw, sd, sup_on, can_on, aux_wr, hs_wr, go;
    logic       tx_en, blk_f, aux_f, pw_f, chip_f, m_n, m_f, m_r;
    logic [1:0] aux_d, aux_ctrl, can_fail;
    logic [3:0] hs_ot, hs_d, hs_ctrl, hs_f;
    logic [8:0] mask, clr;
    int         err_total, samples_checked, cyc, n;
////////////////////////////////////////
    always #12.5 SYS_CLK = ~SYS_CLK;
    tps_supervisor #(.N_HS(4), .COOLDOWN_CYCLES(20), .RESTART_CYCLES(10)) tps_supervisor_i (
        .SYS_CLK(SYS_CLK), .RSTN(RSTN), .AUX_OT_RAW(aux_ot), .CAN_OT_RAW(can_ot), .HS_OT_RAW(hs_ot),
        .MAIN_PW_RAW(pw), .MAIN_SD_RAW(sd), .MAIN_SUPPLY_ON(sup_on), .CAN_ON(can_on),
        .AUX_CTRL_WR(aux_wr), .AUX_CTRL_WDATA(aux_d), .HS_CTRL_WR(hs_wr), .HS_CTRL_WDATA(hs_d),
        .CLR_BLOCK_OT(clr[4]), .CLR_AUX_OT(clr[5]), .CLR_CAN_FAIL(clr[6]), .CLR_HS_FAULT(clr[3:0]),
        .CLR_PREWARN(clr[7]), .CLR_CHIP_OT(clr[8]), .AUX_SUPPLY_ON_CTRL(aux_ctrl),
        .HIGH_SIDE_CONTROL(hs_ctrl), .CAN_TX_EN(tx_en), .BLOCK_OVERTEMP_FLAG(blk_f),
        .AUX_SUPPLY_OVERTEMP_FLAG(aux_f), .CAN_FAIL(can_fail), .HIGH_SIDE_FAULT_FLAG(hs_f),
        .THERMAL_PREWARN_FLAG(pw_f), .CHIP_OVERTEMP_FLAG(chip_f), .MODE_NORMAL(m_n),
        .MODE_FAILSAFE(m_f), .MODE_RESTART(m_r));
    tps_mcu_model tps_mcu_model_i (.clk(SYS_CLK), .rstn(RSTN), .go(go), .mask(mask), .clr(clr));
    task automatic w(input int k);
        repeat (k) @(posedge SYS_CLK);
    endtask
    task automatic look(input int k);
        w(k);
        @(negedge SYS_CLK);
    endtask
    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic clear(input logic [8:0] m);
        w(1);
        go <= 1'h1;
        mask <= m;
        w(1);
        go <= 1'h0;
        look(2);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 1000) begin
            err_total++;
            final_report;
        end
    end
    initial begin
        {aux_ot, can_ot, pw, sd, sup_on, can_on, aux_wr, hs_wr, go} = 9'h000;
        {aux_d, hs_ot, hs_d, mask} = 19'h00000;
        w(8);
        RSTN <= 1'h1;
        look(1);
        chk("mode", 4'h1, {3'h0, m_n});
        w(1);
        aux_ot <= 1'h1;
        look(6);
        chk("aux_off", 4'h0, {3'h0, aux_f});
        w(1);
        aux_wr <= 1'h1;
        aux_d <= 2'h1;
        w(1);
        aux_wr <= 1'h0;
        look(3);
        chk("aux_shut", 4'h3, {aux_ctrl, aux_f, blk_f});
        clear(9'h030);
        chk("hot_clr", 4'h3, {aux_ctrl, aux_f, blk_f});
        w(1);
        aux_ot <= 1'h0;
        look(4);
        clear(9'h030);
        chk("cool_clr", 4'h0, {aux_ctrl, aux_f, blk_f});
        w(1);
        can_ot <= 1'h1;
        look(4);
        chk("can_off", 4'h0, {tx_en, can_fail, blk_f});
        w(1);
        can_on <= 1'h1;
        look(4);
        chk("can_hot", 4'h3, {tx_en, can_fail, blk_f});
        w(1);
        can_ot <= 1'h0;
        look(4);
        chk("can_cool", 4'hb, {tx_en, can_fail, blk_f});
        clear(9'h050);
        chk("can_clr", 4'h8, {tx_en, can_fail, blk_f});
        w(1);
        hs_wr <= 1'h1;
        hs_d <= 4'h5;
        w(1);
        hs_wr <= 1'h0;
        hs_ot <= 4'h2;
        look(4);
        chk("hs_off", 4'h5, hs_ctrl);
        w(1);
        hs_ot <= 4'h4;
        look(4);
        chk("hs_ctrl", 4'h0, hs_ctrl);
        chk("hs_f", 4'h5, hs_f);
        w(1);
        hs_ot <= 4'h0;
        clear(9'h01f);
        chk("hs_clr", 4'h0, hs_f);
        w(1);
        pw <= 1'h1;
        sd <= 1'h1;
        look(5);
        chk("gated", 4'h1, {pw_f, chip_f, m_f, m_n});
        w(1);
        sup_on <= 1'h1;
        look(2);
        chk("chip_sd", 4'he, {pw_f, chip_f, m_f, m_n});
        clear(9'h180);
        chk("hot_keep", 4'he, {pw_f, chip_f, m_f, m_n});
        w(1);
        pw <= 1'h0;
        sd <= 1'h0;
        clear(9'h180);
        chk("fs_clr", 4'h6, {pw_f, chip_f, m_f, m_n});
        n = 0;
        while (m_n !== 1'h1 && n < 100) begin
            look(1);
            n++;
        end
        look(1);
        chk("auto_norm", 4'h1, {m_r, m_f, 1'h0, m_n});
        clear(9'h100);
        chk("chip_clr", 4'h0, {3'h0, chip_f});
        final_report;
    end
endmodule // tb
bind tps_supervisor tps_supervisor_asserts #(.N_HS(N_HS), .COOLDOWN_CYCLES(COOLDOWN_CYCLES)) tps_supervisor_asserts_i (
    .SYS_CLK, .RSTN, .CAN_OT_RAW, .MAIN_SUPPLY_ON, .CAN_ON, .CLR_CHIP_OT, .AUX_SUPPLY_ON_CTRL,
    .HIGH_SIDE_CONTROL, .CAN_TX_EN, .BLOCK_OVERTEMP_FLAG, .AUX_SUPPLY_OVERTEMP_FLAG, .CAN_FAIL,
    .HIGH_SIDE_FAULT_FLAG, .THERMAL_PREWARN_FLAG, .CHIP_OVERTEMP_FLAG, .MODE_NORMAL, .MODE_FAILSAFE,
    .MODE_RESTART);
`default_nettype wire
